/* src/sapfc_pkg.sv */
// constants for the converter control block
package sapfc_pkg;
   // register addresses on the internal special-function bus
   localparam logic [15:0] ADDR_RESULT_LO = 16'hff08;
   localparam logic [15:0] ADDR_RESULT_HI = 16'hff09;
   localparam logic [15:0] ADDR_MODE      = 16'hff28;
   localparam logic [15:0] ADDR_CHANNEL   = 16'hff29;
   localparam logic [15:0] ADDR_FAIL_MODE = 16'hff2a;
   localparam logic [15:0] ADDR_THRESHOLD = 16'hff2b;
   // field positions
   localparam int RUN_BIT      = 7;
   localparam int REFGEN_BIT   = 0;
   localparam int TSEL_LSB     = 3;
   localparam int FAIL_EN_BIT  = 7;
   localparam int POLARITY_BIT = 6;
   // write masks: unimplemented bits read as zero
   localparam logic [7:0] MODE_MASK      = 8'hb9;
   localparam logic [7:0] CHANNEL_MASK   = 8'h03;
   localparam logic [7:0] FAIL_MODE_MASK = 8'hc0;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam int RES_BITS = 10;
   localparam int RESULT_PAD = 6;
   // conversion periods in system clocks per time-select code
   localparam logic [8:0] PER_288 = 9'd288;
   localparam logic [8:0] PER_240 = 9'd240;
   localparam logic [8:0] PER_192 = 9'd192;
   localparam logic [8:0] PER_144 = 9'd144;
   localparam logic [8:0] PER_120 = 9'd120;
   localparam logic [8:0] PER_96  = 9'd96;
   localparam int SAMPLE_DIV = 6;
   localparam real REF_SETTLE_US = 14.0;
   localparam real CLK_MHZ = 40.0;
   localparam int REF_SETTLE_CYC = int'($ceil(REF_SETTLE_US * CLK_MHZ));
endpackage

/* src/sapfc_ctrl.sv */
// 10-bit successive-approximation converter control with power-fail compare
`timescale 1ns/1ps
module sapfc_ctrl
   import sapfc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // cpu special-function bus
   input  wire logic [15:0] bus_addr_i,
   input  wire logic        bus_wr_i,
   input  wire logic        bus_rd_i,
   input  wire logic [7:0]  bus_wdata_i,
   output logic      [7:0]  bus_rdata_o,
   output logic             bus_wait_o,
   // analog front end
   output logic      [1:0]  chan_sel_o,
   output logic             sample_o,
   output logic             hold_o,
   output logic      [9:0]  tap_code_o,
   input  wire logic        comp_ge_i,
   output logic             ref_gen_enable_o,
   // events
   output logic             conv_done_irq_o
);

   typedef enum logic [1:0]
   {
      SAPFC_IDLE   = 2'b00,
      SAPFC_SAMPLE = 2'b01,
      SAPFC_DECIDE = 2'b10
   } sapfc_state_e;

   typedef struct packed
   {
      sapfc_state_e state;
      logic [7:0]   mode;
      logic [7:0]   channel;
      logic [7:0]   fail_mode;
      logic [7:0]   threshold;
      logic [9:0]   approx;
      logic [9:0]   result;
      logic [3:0]   bit_idx;
      logic [8:0]   cnt;
      logic         irq;
      logic         waited;
      logic [7:0]   rdata;
   } sapfc_s;

   sapfc_s q, d;

   // period lookup, used for both sample and decision spacing
   function automatic logic [8:0] conv_period(input logic [2:0] sel);
      unique case (sel)
         3'b000:  conv_period = PER_288;
         3'b001:  conv_period = PER_240;
         3'b010:  conv_period = PER_192;
         3'b100:  conv_period = PER_144;
         3'b101:  conv_period = PER_120;
         3'b110:  conv_period = PER_96;
         default: conv_period = PER_288; // prohibited codes
      endcase
   endfunction

   logic [8:0] period;
   logic [8:0] sample_len;
   logic [8:0] step_len;
   logic       cfg_wr;
   logic       wait_req;
   logic       qualifies;
   logic       busy;

   assign period     = conv_period(q.mode[TSEL_LSB +: 3]);
   // first sixth samples, rest split across ten decisions
   assign sample_len = 9'(period / SAMPLE_DIV);
   assign step_len   = 9'((period - sample_len) / RES_BITS);
   assign busy       = (q.state != SAPFC_IDLE);
   assign cfg_wr     = bus_wr_i && !bus_wait_o &&
                       (bus_addr_i == ADDR_MODE ||
                        bus_addr_i == ADDR_CHANNEL ||
                        bus_addr_i == ADDR_FAIL_MODE ||
                        bus_addr_i == ADDR_THRESHOLD);
   // one wait on the first cycle of a config write
   assign wait_req   = bus_wr_i && !q.waited &&
                       (bus_addr_i == ADDR_MODE ||
                        bus_addr_i == ADDR_CHANNEL ||
                        bus_addr_i == ADDR_FAIL_MODE ||
                        bus_addr_i == ADDR_THRESHOLD);
   assign bus_wait_o = wait_req;

   // compare against the decided value, upper eight bits only
   always_comb
   begin
      logic [9:0] fin;
      fin = q.approx;
      if (!comp_ge_i)
         fin[0] = 1'b0;
      if (!q.fail_mode[FAIL_EN_BIT])
         qualifies = 1'b1;
      else if (!q.fail_mode[POLARITY_BIT])
         qualifies = (fin[9:2] >= q.threshold);
      else
         qualifies = (fin[9:2] < q.threshold);
   end

   always_comb
   begin
      d        = q;
      d.irq    = 1'b0; // pulse only
      d.waited = wait_req;
      d.cnt    = q.cnt + 9'd1;
      // register reads return state; bits below the two low result bits read zero
      unique case (bus_addr_i)
         ADDR_RESULT_HI: d.rdata = q.result[9:2];
         ADDR_RESULT_LO: d.rdata = {q.result[1:0], 6'h00};
         ADDR_MODE:      d.rdata = q.mode;
         ADDR_CHANNEL:   d.rdata = q.channel;
         ADDR_FAIL_MODE: d.rdata = q.fail_mode;
         ADDR_THRESHOLD: d.rdata = q.threshold;
         default:        d.rdata = 8'h00;
      endcase
      unique case (q.state)
         SAPFC_IDLE:
         begin
            if (q.mode[RUN_BIT])
            begin
               d.state = SAPFC_SAMPLE;
               d.cnt   = 9'd0;
            end
         end
         SAPFC_SAMPLE:
         begin
            if (q.cnt >= sample_len - 9'd1)
            begin
               // hold, then set MSB with tap at half reference
               d.state   = SAPFC_DECIDE;
               d.approx  = 10'h200;
               d.bit_idx = 4'd9;
               d.cnt     = 9'd0;
            end
         end
         SAPFC_DECIDE:
         begin
            if (q.cnt >= step_len - 9'd1)
            begin
               d.cnt = 9'd0;
               // keep bit when input is at least tap
               if (!comp_ge_i)
                  d.approx[q.bit_idx] = 1'b0;
               if (q.bit_idx == 4'd0)
               begin
                  d.result = d.approx; // overwrites unread data
                  d.irq    = qualifies;
                  d.state  = SAPFC_SAMPLE; // back to back
               end
               else
               begin
                  d.bit_idx = q.bit_idx - 4'd1;
                  d.approx[q.bit_idx - 4'd1] = 1'b1;
               end
            end
         end
         default: d.state = SAPFC_IDLE;
      endcase
      // config writes abort and restart from sampling when the run bit is set after the write
      if (cfg_wr)
      begin
         unique case (bus_addr_i)
            ADDR_MODE:      d.mode      = bus_wdata_i & MODE_MASK;
            ADDR_CHANNEL:   d.channel   = bus_wdata_i & CHANNEL_MASK;
            ADDR_FAIL_MODE: d.fail_mode = bus_wdata_i & FAIL_MODE_MASK;
            default:        d.threshold = bus_wdata_i;
         endcase
         d.irq   = 1'b0; // aborted conversion raises nothing
         d.cnt   = 9'd0;
         d.state = SAPFC_IDLE; // halts when run cleared
         if (bus_addr_i == ADDR_MODE ? bus_wdata_i[RUN_BIT]
                                     : q.mode[RUN_BIT])
            d.state = SAPFC_SAMPLE;
      end
      else if (!q.mode[RUN_BIT])
         d.state = SAPFC_IDLE;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         q.state     <= SAPFC_IDLE;
         q.mode      <= REG_RESET;
         q.channel   <= REG_RESET;
         q.fail_mode <= REG_RESET;
         q.threshold <= REG_RESET;
         q.approx    <= 10'h000;
         q.bit_idx   <= 4'd0;
         q.cnt       <= 9'd0;
         q.irq       <= 1'b0;
         q.waited    <= 1'b0;
         q.rdata     <= 8'h00;
         q.result    <= d.result; // left as is over reset
      end
      else
         q <= d;
   end

   assign bus_rdata_o      = q.rdata;
   assign chan_sel_o       = q.channel[1:0];
   assign sample_o         = (q.state == SAPFC_SAMPLE);
   assign hold_o           = (q.state == SAPFC_DECIDE);
   assign tap_code_o       = q.approx;
   assign ref_gen_enable_o = q.mode[REFGEN_BIT];
   assign conv_done_irq_o  = q.irq;

   // decisions start from the MSB with the tap at half scale
   sequence s_hold_start;
      $rose(hold_o);
   endsequence
   property p_msb_first;
      @(posedge sys_clk_i) disable iff (reset_i)
      s_hold_start |-> tap_code_o == 10'h200;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("conversion did not start at half scale");

   property p_irq_pulse;
      @(posedge sys_clk_i) disable iff (reset_i)
      conv_done_irq_o |=> !conv_done_irq_o;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("interrupt longer than one cycle");

   property p_plain_irq;
      @(posedge sys_clk_i) disable iff (reset_i)
      ($fell(hold_o) && $past(q.bit_idx) == 4'd0 && !$past(cfg_wr)
       && !$past(q.fail_mode[FAIL_EN_BIT])) |-> conv_done_irq_o;
   endproperty
   a_plain_irq: assert property (p_plain_irq)
      else $error("missing interrupt in plain mode");

   property p_fail_cmp;
      @(posedge sys_clk_i) disable iff (reset_i)
      (conv_done_irq_o && q.fail_mode[FAIL_EN_BIT]) |->
         (q.fail_mode[POLARITY_BIT] ? q.result[9:2] < q.threshold
                                    : q.result[9:2] >= q.threshold);
   endproperty
   a_fail_cmp: assert property (p_fail_cmp)
      else $error("interrupt against threshold condition");

   property p_wait;
      @(posedge sys_clk_i) disable iff (reset_i)
      (bus_wr_i && !$past(bus_wr_i) &&
       (bus_addr_i == ADDR_THRESHOLD || bus_addr_i == ADDR_FAIL_MODE))
         |-> bus_wait_o;
   endproperty
   a_wait: assert property (p_wait)
      else $error("no wait on threshold write");

   property p_abort;
      @(posedge sys_clk_i) disable iff (reset_i)
      cfg_wr |=> !conv_done_irq_o && !hold_o;
   endproperty
   a_abort: assert property (p_abort)
      else $error("write did not abort conversion");

   property p_stop;
      @(posedge sys_clk_i) disable iff (reset_i)
      (cfg_wr && bus_addr_i == ADDR_MODE && !bus_wdata_i[RUN_BIT])
         |=> !sample_o && !hold_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("conversion not halted");

   property p_restart;
      @(posedge sys_clk_i) disable iff (reset_i)
      (conv_done_irq_o || ($fell(hold_o) && q.mode[RUN_BIT]
       && !$past(cfg_wr))) |-> sample_o;
   endproperty
   a_restart: assert property (p_restart)
      else $error("no back to back conversion");

   property p_chan;
      @(posedge sys_clk_i) disable iff (reset_i)
      (cfg_wr && bus_addr_i == ADDR_CHANNEL)
         |=> chan_sel_o == $past(bus_wdata_i[1:0]);
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel not taken from write");

   property p_wait_once;
      @(posedge sys_clk_i) disable iff (reset_i)
      bus_wait_o |=> !bus_wait_o;
   endproperty
   a_wait_once: assert property (p_wait_once)
      else $error("wait held longer than one cycle");

   // hold may only begin once the full sampling share has elapsed
   property p_sample_then_hold;
      @(posedge sys_clk_i) disable iff (reset_i)
      s_hold_start |-> $past(sample_o) &&
         $past(q.cnt) == $past(sample_len) - 9'd1;
   endproperty
   a_sample_then_hold: assert property (p_sample_then_hold)
      else $error("hold began before sampling finished");

   property p_result_load;
      @(posedge sys_clk_i) disable iff (reset_i)
      ($fell(hold_o) && !$past(cfg_wr))
         |-> q.result[9:1] == $past(q.approx[9:1]);
   endproperty
   a_result_load: assert property (p_result_load)
      else $error("result not loaded from approximation");

   property p_irq_done;
      @(posedge sys_clk_i) disable iff (reset_i)
      conv_done_irq_o |-> $fell(hold_o) && $past(q.bit_idx) == 4'd0;
   endproperty
   a_irq_done: assert property (p_irq_done)
      else $error("interrupt without a finished conversion");

   property p_low_zero;
      @(posedge sys_clk_i) disable iff (reset_i)
      $past(bus_addr_i) == ADDR_RESULT_LO |-> bus_rdata_o[5:0] == 6'h00;
   endproperty
   a_low_zero: assert property (p_low_zero)
      else $error("low result bits not zero");
endmodule

/* dv/sapfc_analog_model.sv */
// analog front end model: four channel levels, sample-hold and comparator
`timescale 1ns/1ps
module sapfc_analog_model
(
   // clock and front-end controls
   input  wire logic       sys_clk_i,
   input  wire logic [1:0] chan_sel_i,
   input  wire logic       sample_i,
   input  wire logic [9:0] tap_code_i,
   // comparator
   output logic            comp_ge_o
);
   logic [9:0] level_q [4];
   logic [9:0] held_q = 10'h000;
   always @(posedge sys_clk_i)
      if (sample_i)
         held_q <= level_q[chan_sel_i];
   // frozen outside sampling so every decision sees one voltage
   assign comp_ge_o = (held_q >= tap_code_i);
endmodule

/* dv/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
   import sapfc_pkg::*;
   logic        sys_clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        wait_w, smp, hold, ge, refen, irq;
   logic [1:0]  chan;
   logic [9:0]  tap;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          n_irq = 0;
   int          c, k0;
   localparam logic [7:0] CODES [8] = '{8'h81, 8'h89, 8'h91, 8'ha1,
      8'ha9, 8'hb1, 8'h99, 8'hb9};
   localparam int PERIODS [8] = '{288, 240, 192, 144, 120, 96, 288, 288};
   localparam logic [9:0] LVL [4] = '{10'h155, 10'h2a4, 10'h3ff, 10'h000};
   always #12.5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i)
      if (irq === 1'b1)
         n_irq <= n_irq + 1;
   sapfc_ctrl sapfc_ctrl_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .bus_addr_i(addr), .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata),
      .bus_rdata_o(rdata), .bus_wait_o(wait_w), .chan_sel_o(chan),
      .sample_o(smp), .hold_o(hold), .tap_code_o(tap), .comp_ge_i(ge),
      .ref_gen_enable_o(refen), .conv_done_irq_o(irq));
   sapfc_analog_model sapfc_analog_model_inst (.sys_clk_i(sys_clk_i),
      .chan_sel_i(chan), .sample_i(smp), .tap_code_i(tap), .comp_ge_o(ge));
   initial
      for (int i = 0; i < 4; i++)
         sapfc_analog_model_inst.level_q[i] = LVL[i];
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      int w;
      w = 0;
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(negedge sys_clk_i);
      while (wait_w !== 1'b0 && w < 8)
      begin
         w++;
         @(negedge sys_clk_i);
      end
      @(posedge sys_clk_i);
      wr <= 1'b0;
      if (a[15:2] == 14'h3fca)
         chk(16'(w), 16'h0001);
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk(16'(rdata), 16'(e));
      @(posedge sys_clk_i);
      rd <= 1'b0;
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      do
      begin
         @(negedge sys_clk_i);
         n++;
      end
      while (irq !== 1'b1 && n < 1000);
   endtask
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", samples_checked,
         n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #1000000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      rchk(ADDR_THRESHOLD, 8'h00);
      rchk(ADDR_FAIL_MODE, 8'h00);
      rchk(ADDR_CHANNEL, 8'h00);
      $display("test reset values done");
      wr_reg(ADDR_MODE, 8'h31);
      repeat (REF_SETTLE_CYC) @(posedge sys_clk_i);
      chk(16'(refen), 16'h0001);
      wr_reg(ADDR_MODE, 8'hb1);
      for (int ch = 0; ch < 4; ch++)
      begin
         wr_reg(ADDR_CHANNEL, 8'(ch));
         wait_irq(c);
         chk(16'(c < 1000), 16'h0001);
         chk(16'({smp, hold}), 16'h0002);
         chk(16'(chan), 16'(ch));
         @(negedge sys_clk_i);
         chk(16'(irq), 16'h0000);
         rchk(ADDR_RESULT_HI, LVL[ch][9:2]);
         rchk(ADDR_RESULT_LO, {LVL[ch][1:0], 6'h00});
      end
      $display("test channel results done");
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(ADDR_MODE, CODES[i]);
         wait_irq(c);
         wait_irq(c);
         chk(16'(c), 16'(PERIODS[i]));
      end
      $display("test conversion times done");
      wr_reg(ADDR_MODE, 8'hb1);
      wr_reg(ADDR_CHANNEL, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(ADDR_FAIL_MODE, i < 2 ? 8'h80 : 8'hc0);
         wr_reg(ADDR_THRESHOLD, (i == 0 || i == 3) ? 8'ha9 : 8'haa);
         k0 = n_irq;
         repeat (300) @(posedge sys_clk_i);
         chk(16'(n_irq != k0), 16'(i == 0 || i == 2));
      end
      rchk(ADDR_THRESHOLD, 8'ha9);
      wr_reg(ADDR_FAIL_MODE, 8'h00);
      $display("test threshold compare done");
      k0 = n_irq;
      repeat (6)
      begin
         wr_reg(ADDR_MODE, 8'hb1);
         repeat (60) @(posedge sys_clk_i);
         @(negedge sys_clk_i);
         chk(16'(hold), 16'h0001);
      end
      chk(16'(n_irq - k0), 16'h0000);
      wait_irq(c);
      chk(16'(c <= 40), 16'h0001);
      wr_reg(ADDR_MODE, 8'h31);
      k0 = n_irq;
      repeat (400) @(posedge sys_clk_i);
      chk(16'(n_irq - k0), 16'h0000);
      wr_reg(ADDR_MODE, 8'h00);
      $display("test abort and stop done");
      // no reference: first result is not trusted, second is used
      wr_reg(ADDR_MODE, 8'h80);
      wait_irq(c);
      wait_irq(c);
      chk(16'(c), 16'h0120);
      chk(16'(refen), 16'h0000);
      rchk(ADDR_RESULT_HI, LVL[1][9:2]);
      wr_reg(ADDR_MODE, 8'h00);
      $display("test start without reference done");
      summarize();
   end
endmodule
